/* rtl/adcf_seq.sv */
// adcf_seq: control register, trigger selection, conversion sequencer and
// result formatting for a 12-bit successive-approximation converter
// assumes the converter core holds core_code valid at the end of bit trials,
// and timer and logic-array triggers are one-cycle pulses on mclk
`timescale 1ns/10ps
`default_nettype none
module adcf_seq (
  input wire logic mclk, // adc source clock, 10 MHz
  input wire logic rst, // synchronous reset, active high
  input wire adcf_pkg::adcf_mmr_type memory_mapped_register, // processor register access
  output logic [31:0] rdata, // read data, valid the cycle after rd
  input wire logic ext_conversion_trigger_pin, // asynchronous start pin
  input wire logic timer0_trig, // timer zero overflow pulse
  input wire logic timer1_trig, // timer one overflow pulse
  input wire logic logic_array_trig, // logic array start pulse
  input wire logic temp_channel, // selected channel is the temperature sensor
  input wire logic [11:0] core_code, // raw code from the converter core
  output logic sample_hold, // track phase active
  output logic converting, // conversion sequence active
  output logic result_ready, // unread result waiting
  output logic power_on, // converter powered
  output logic diff_mode, // differential input mode
  output logic temp_sensor_en, // temperature conversion enable bit
  output logic adc_ready // powered long enough to convert
);

  // registers
  adcf_pkg::adcf_ctrl_type ctrl_q; // control register
  adcf_pkg::adcf_ctrl_type ctrl_d;
  adcf_pkg::adcf_state_type state_q; // sequencer state
  adcf_pkg::adcf_state_type state_d;
  logic [31:0] result_q; // formatted result
  logic [31:0] rdata_q; // read data
  logic [4:0] phase_q; // adc clocks spent in the phase
  logic [4:0] phase_d;
  logic [2:0] pin_q; // two-flop sync plus edge history
  logic cont_q; // continuous mode running
  logic temp_q; // temperature timing in force
  logic valid_q; // unread result
  logic sample_q; // registered track phase
  logic busy_q; // registered busy
  logic [5:0] pwr_cnt_q; // power-up timer
  logic ready_q; // power-up elapsed
  logic diff_q; // registered differential-mode decode

  // wires
  logic tick; // one adc clock elapsed
  logic ctrl_wr; // control register write
  logic res_rd; // result register read
  logic pin_edge; // rising edge on the pin
  logic type_trig; // selected trigger fired
  logic start; // begin a conversion
  logic sw_done; // single conversion finished
  logic [2:0] use_div; // divider code in force
  logic [1:0] use_acq; // acquisition code in force
  logic [4:0] acq_len; // acquisition clocks in force
  logic acq_end; // last acquisition clock
  logic trial_end; // last trial clock
  logic [11:0] fmt_code; // formatted 12-bit value
  logic fmt_sign; // sign for extension
  logic [31:0] result_d;
  logic [31:0] rdata_d;
  adcf_pkg::adcf_ctrl_type temp_set; // fixed temperature timing

  // address decode
  assign ctrl_wr = memory_mapped_register.wr && memory_mapped_register.addr == adcf_pkg::ADDR_CONTROL;
  assign res_rd = memory_mapped_register.rd && memory_mapped_register.addr == adcf_pkg::ADDR_RESULT;

  // the pin edge is taken from the second sync stage only
  assign pin_edge = pin_q[1] && !pin_q[2];

  // trigger source select
  assign type_trig =
    (ctrl_q.conv_type == adcf_pkg::TYPE_PIN && pin_edge) ||
    (ctrl_q.conv_type == adcf_pkg::TYPE_TIMER1 && timer1_trig) ||
    (ctrl_q.conv_type == adcf_pkg::TYPE_TIMER0 && timer0_trig) ||
    (ctrl_q.conv_type == adcf_pkg::TYPE_SINGLE) ||
    (ctrl_q.conv_type == adcf_pkg::TYPE_CONT) ||
    (ctrl_q.conv_type == adcf_pkg::TYPE_LOGIC && logic_array_trig); // RULE_14

  // starts need the enable bit, but a running continuous sequence carries on
  assign start = state_q == adcf_pkg::ST_IDLE &&
    ((ctrl_q.start_en && type_trig) || cont_q); // RULE_15

  // temperature conversions run on fixed slow timing until the result is read
  assign temp_set = adcf_pkg::adcf_ctrl_type'(adcf_pkg::TEMP_SETTING); // RULE_12
  assign use_div = temp_q ? temp_set.clk_div : ctrl_q.clk_div; // RULE_13
  assign use_acq = temp_q ? temp_set.acq : ctrl_q.acq; // RULE_13
  assign acq_len = adcf_pkg::acq_clocks(use_acq); // RULE_09
  assign acq_end = tick && phase_q == acq_len - 5'h01; // RULE_09
  assign trial_end = tick && phase_q == adcf_pkg::TRIAL_CLOCKS - 5'h01; // RULE_07

  // single software conversion returns its type field to the pin trigger
  assign sw_done = state_q == adcf_pkg::ST_WRITE &&
    ctrl_q.conv_type == adcf_pkg::TYPE_SINGLE; // RULE_14

  // a processor write in the same cycle as the self-clear is the newer value
  assign ctrl_d = ctrl_wr ?
    adcf_pkg::adcf_ctrl_type'(memory_mapped_register.wdata[15:0] & adcf_pkg::CONTROL_WMASK) :
    sw_done ? adcf_pkg::adcf_ctrl_type'({ctrl_q[15:3], adcf_pkg::TYPE_PIN}) : ctrl_q; // RULE_14

  // result formatting: binary, or offset code to twos complement shifted by one
  assign fmt_code = (ctrl_q.mode == adcf_pkg::MODE_DIFF) ?
    {~core_code[11], ~core_code[11], core_code[10:1]} : core_code; // RULE_02 RULE_03 RULE_04
  assign fmt_sign = ctrl_q.mode == adcf_pkg::MODE_DIFF && fmt_code[11]; // RULE_06
  assign result_d = {{4{fmt_sign}}, fmt_code, 16'h0000}; // RULE_05 RULE_06

  // read mux; reserved and unmapped bits read zero
  assign rdata_d = (memory_mapped_register.addr == adcf_pkg::ADDR_CONTROL) ? {16'h0000, ctrl_q} :
    (memory_mapped_register.addr == adcf_pkg::ADDR_RESULT) ? result_q : 32'h0000_0000;

  // outputs straight from flops
  assign rdata = rdata_q;
  assign sample_hold = sample_q;
  assign converting = busy_q;
  assign result_ready = valid_q;
  assign power_on = ctrl_q.power;
  assign diff_mode = diff_q;
  assign temp_sensor_en = ctrl_q.temp_en; // RULE_11
  assign adc_ready = ready_q;

  // adc clock from the source clock
  adcf_clk_div u_div (
    .mclk(mclk),
    .rst(rst),
    .div_code(use_div),
    .tick(tick)
  );

  // next state of the sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adcf_pkg::ST_IDLE: begin
        if (start) begin
          state_d = adcf_pkg::ST_ACQ;
        end
      end
      adcf_pkg::ST_ACQ: begin
        if (acq_end) begin
          state_d = adcf_pkg::ST_TRIAL; // RULE_09
        end
      end
      adcf_pkg::ST_TRIAL: begin
        if (trial_end) begin
          state_d = adcf_pkg::ST_WRITE; // RULE_07
        end
      end
      adcf_pkg::ST_WRITE: begin
        state_d = adcf_pkg::ST_IDLE;
      end
    endcase
  end

  // phase counter restarts at each state change, counts adc clocks otherwise
  assign phase_d = (state_d != state_q) ? 5'h00 : tick ? phase_q + 5'h01 : phase_q;

  // control register
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= adcf_pkg::adcf_ctrl_type'(adcf_pkg::CONTROL_RESET); // RULE_08
      diff_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      // decoded from the next value so the pin is a flop yet tracks ctrl_q exactly
      diff_q <= ctrl_d.mode == adcf_pkg::MODE_DIFF; // RULE_03
    end
  end

  // sequencer state and counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= adcf_pkg::ST_IDLE;
      phase_q <= 5'h00;
      sample_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      sample_q <= state_d == adcf_pkg::ST_ACQ;
      busy_q <= state_d != adcf_pkg::ST_IDLE;
    end
  end

  // continuous mode stays on until software picks another type
  always_ff @(posedge mclk) begin
    if (rst) begin
      cont_q <= 1'b0;
    end else begin
      cont_q <= ctrl_q.conv_type == adcf_pkg::TYPE_CONT && (cont_q || start); // RULE_15
    end
  end

  // temperature timing: start on that channel sets, result read clears, set wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      temp_q <= 1'b0;
    end else begin
      temp_q <= (start && temp_channel) || (temp_q && !res_rd); // RULE_13
    end
  end

  // result register and its unread flag, a new result beats a read
  always_ff @(posedge mclk) begin
    if (rst) begin
      result_q <= 32'h0000_0000;
      valid_q <= 1'b0;
    end else begin
      if (state_q == adcf_pkg::ST_WRITE) begin
        result_q <= result_d; // RULE_01
      end
      valid_q <= state_q == adcf_pkg::ST_WRITE || (valid_q && !res_rd);
    end
  end

  // read data register, holds until the next read
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (memory_mapped_register.rd) begin
      rdata_q <= rdata_d;
    end
  end

  // pin synchroniser; stage 0 feeds stage 1 only
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_q <= 3'h0;
    end else begin
      pin_q <= {pin_q[1:0], ext_conversion_trigger_pin};
    end
  end

  // power-up settle timer, only advisory: conversions are not blocked by it
  always_ff @(posedge mclk) begin
    if (rst || !ctrl_q.power) begin
      pwr_cnt_q <= 6'h00;
      ready_q <= 1'b0;
    end else begin
      if (!ready_q) begin
        pwr_cnt_q <= pwr_cnt_q + 6'h01;
      end
      ready_q <= ready_q || pwr_cnt_q == 6'(adcf_pkg::POWERUP_CYCLES - 1); // RULE_16
    end
  end

  // ---- assertions ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // helper: adc clocks seen in the present phase
  logic [4:0] h_ticks_q;
  always_ff @(posedge mclk) begin
    if (rst || state_d != state_q) begin
      h_ticks_q <= 5'h00;
    end else if (tick) begin
      h_ticks_q <= h_ticks_q + 5'h01;
    end
  end

  sequence s_write;
    state_q == adcf_pkg::ST_WRITE;
  endsequence

  property p_reset_ctrl;
    rst |=> ctrl_q == adcf_pkg::CONTROL_RESET;
  endproperty
  a_reset_ctrl: assert property (@(posedge mclk) disable iff (1'b0) p_reset_ctrl)
    else $error("control reset value wrong"); // RULE_08

  property p_acq_len;
    state_q == adcf_pkg::ST_ACQ && state_d == adcf_pkg::ST_TRIAL |->
      h_ticks_q + 5'h01 == adcf_pkg::acq_clocks(use_acq);
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition length wrong"); // RULE_09

  property p_trial_len;
    state_q == adcf_pkg::ST_TRIAL && state_d == adcf_pkg::ST_WRITE |->
      h_ticks_q == 5'h12;
  endproperty
  a_trial_len: assert property (p_trial_len) else $error("trial length not 19"); // RULE_07

  property p_single_fmt;
    s_write and ctrl_q.mode == adcf_pkg::MODE_SINGLE |=>
      result_q == {4'h0, $past(core_code), 16'h0000};
  endproperty
  a_single_fmt: assert property (p_single_fmt) else $error("binary result wrong"); // RULE_02

  property p_diff_fmt;
    s_write and ctrl_q.mode == adcf_pkg::MODE_DIFF |=>
      result_q[27:16] == {~$past(core_code[11]), ~$past(core_code[11]), $past(core_code[10:1])};
  endproperty
  a_diff_fmt: assert property (p_diff_fmt) else $error("differential result wrong"); // RULE_04

  property p_sign_ext;
    s_write |=> result_q[31:28] == {4{result_q[27] && diff_mode}} && result_q[15:0] == 16'h0000;
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("result alignment wrong"); // RULE_06

  property p_sw_clear;
    s_write and ctrl_q.conv_type == adcf_pkg::TYPE_SINGLE and !ctrl_wr |=>
      ctrl_q.conv_type == adcf_pkg::TYPE_PIN ##1 state_q == adcf_pkg::ST_IDLE;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("single type not cleared"); // RULE_14

  property p_gate;
    state_q == adcf_pkg::ST_IDLE && !ctrl_q.start_en && !cont_q |=> state_q == adcf_pkg::ST_IDLE;
  endproperty
  a_gate: assert property (p_gate) else $error("start while disabled"); // RULE_15

  property p_cont_keeps;
    s_write and cont_q and ctrl_q.conv_type == adcf_pkg::TYPE_CONT and !ctrl_wr |=>
      state_q == adcf_pkg::ST_IDLE ##1 state_q == adcf_pkg::ST_ACQ;
  endproperty
  a_cont_keeps: assert property (p_cont_keeps) else $error("continuous run stopped"); // RULE_15

  property p_temp_revert;
    res_rd && !(start && temp_channel) |=> !temp_q && use_div == ctrl_q.clk_div;
  endproperty
  a_temp_revert: assert property (p_temp_revert) else $error("user timing not restored"); // RULE_13

endmodule
`default_nettype wire

/* shared/adcf_pkg.sv */
// adcf_pkg: constants, field layout and carrier types for the adc sequencer
// assumes one 10 MHz clock (mclk) and a synchronous active-high reset
// Summary of operation
// RULE_01: completed conversion leaves 12-bit result in register
// RULE_02: single-ended result is straight binary code
// RULE_03: differential result is twos complement code
// RULE_04: differential value shifted right one, signed integer
// RULE_05: result sits in bits 16 to 27
// RULE_06: four bits above result copy the sign
// RULE_07: conversion is acquisition plus 19 adc clocks
// RULE_08: reset gives eight acquisition clocks, divide by two
// RULE_09: acquisition code selects 2, 4, 8, 16 clocks
// RULE_10: clock code 000-101 divides by 1 to 32
// RULE_11: software sets temp bit for temp/single conversions
// RULE_12: software writes 0x37A3 before temperature conversion
// RULE_13: user timing returns after temperature result is read
// RULE_14: type field picks trigger; single clears to 000
// RULE_15: bit 7 gates starts; continuous keeps running
// RULE_16: software powers up, waits 5 us before use
// RULE_17: clock codes 110/111 keep previous divider
package adcf_pkg;

  // register map
  localparam logic [31:0] ADDR_CONTROL = 32'hffff_0500; // control register
  localparam logic [31:0] ADDR_RESULT = 32'hffff_0510; // result register
  localparam logic [15:0] CONTROL_RESET = 16'h0600; // acq 8 clocks, divide by 2
  localparam logic [15:0] CONTROL_WMASK = 16'h3fbf; // reserved bits 15:14 and 6 read zero
  localparam logic [15:0] TEMP_SETTING = 16'h37a3; // timing used for the temperature channel

  // field positions in the control register
  localparam int TEMP_EN_BIT = 13; // temperature conversion enable
  localparam int CLK_LSB = 10; // clock speed field, 3 bits
  localparam int ACQ_LSB = 8; // acquisition field, 2 bits
  localparam int START_EN_BIT = 7; // start enable
  localparam int POWER_BIT = 5; // power control
  localparam int MODE_LSB = 3; // conversion mode, 2 bits
  localparam int TYPE_LSB = 0; // conversion type, 3 bits

  // conversion type codes
  localparam logic [2:0] TYPE_PIN = 3'h0; // external pin edge
  localparam logic [2:0] TYPE_TIMER1 = 3'h1; // timer one overflow
  localparam logic [2:0] TYPE_TIMER0 = 3'h2; // timer zero overflow
  localparam logic [2:0] TYPE_SINGLE = 3'h3; // single software conversion
  localparam logic [2:0] TYPE_CONT = 3'h4; // continuous software conversion
  localparam logic [2:0] TYPE_LOGIC = 3'h5; // programmable logic array

  // conversion mode codes
  localparam logic [1:0] MODE_SINGLE = 2'h0; // single-ended
  localparam logic [1:0] MODE_DIFF = 2'h1; // fully differential

  // divider
  localparam logic [2:0] DIV_RESET = 3'h1; // divide by two
  localparam logic [2:0] DIV_MAX_CODE = 3'h5; // divide by 32, highest legal code

  // result layout
  localparam int RESULT_LSB = 16; // low bit of the code
  localparam int RESULT_MSB = 27; // high bit of the code
  localparam logic [4:0] TRIAL_CLOCKS = 5'h13; // 19 adc clocks of bit trials; write-back takes one more cycle

  // timing
  localparam int CLK_PERIOD_NS = 100; // 10 MHz
  localparam int POWERUP_US = 5; // settle time after power-up
  localparam int POWERUP_CYCLES = (POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // control register layout
  typedef struct packed {
    logic [1:0] rsv_hi; // reads zero
    logic temp_en; // temperature conversion enable
    logic [2:0] clk_div; // clock speed code
    logic [1:0] acq; // acquisition code
    logic start_en; // start enable
    logic rsv6; // reads zero
    logic power; // converter powered
    logic [1:0] mode; // single-ended or differential
    logic [2:0] conv_type; // trigger source
  } adcf_ctrl_type;

  // memory-mapped access from the processor
  typedef struct packed {
    logic [31:0] addr; // byte address
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
    logic [31:0] wdata; // write data
  } adcf_mmr_type;

  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_TRIAL, ST_WRITE} adcf_state_type;

  // acquisition length in adc clocks for a code
  function automatic logic [4:0] acq_clocks(input logic [1:0] code);
    acq_clocks = 5'h02 << code;
  endfunction

endpackage

/* rtl/adcf_clk_div.sv */
// adcf_clk_div: adc clock divider producing a one-cycle tick per adc clock
// assumes div_code comes from registers on the same clock
`timescale 1ns/10ps
`default_nettype none
module adcf_clk_div (
  input wire logic mclk, // adc source clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [2:0] div_code, // requested clock speed code
  output logic tick // one adc clock period elapsed
);

  logic [2:0] held_q; // last legal divider code
  logic [4:0] cnt_q; // cycles within the adc clock
  logic [4:0] cnt_max; // divisor minus one
  logic code_ok; // requested code is legal
  logic tick_q; // registered tick

  assign code_ok = div_code <= adcf_pkg::DIV_MAX_CODE; // RULE_17
  assign cnt_max = 5'((6'h01 << held_q) - 6'h01); // RULE_10
  assign tick = tick_q;

  // keep the previous divider for reserved codes so no odd clock appears
  always_ff @(posedge mclk) begin
    if (rst) begin
      held_q <= adcf_pkg::DIV_RESET; // RULE_08
    end else if (code_ok) begin
      held_q <= div_code; // RULE_17
    end
  end

  // free-running divider counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= (cnt_q >= cnt_max) ? 5'h00 : cnt_q + 5'h01; // RULE_10
      tick_q <= cnt_q >= cnt_max;
    end
  end

  // helper: gap since last tick, and whether the divider changed inside it
  logic [5:0] h_gap_q;
  logic h_dirty_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      h_gap_q <= 6'h00;
      h_dirty_q <= 1'b1;
    end else begin
      h_gap_q <= tick_q ? 6'h00 : h_gap_q + 6'h01;
      h_dirty_q <= (held_q != div_code && code_ok) || (h_dirty_q && !tick_q);
    end
  end

  property p_div_period;
    @(posedge mclk) disable iff (rst)
    tick_q && !h_dirty_q |-> h_gap_q == {1'b0, cnt_max};
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider period wrong"); // RULE_10

  property p_div_hold;
    @(posedge mclk) disable iff (rst)
    !code_ok |=> held_q == $past(held_q);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("reserved code changed divider"); // RULE_17

endmodule
`default_nettype wire

/* bench/adcf_core_model.sv */
// adcf_core_model: converter core and trigger sources facing adcf_seq
// assumes the bench sets code_set and pulses fire for one mclk cycle
`timescale 1ns/10ps
`default_nettype none
module adcf_core_model (
  input wire logic mclk, // adc source clock
  input wire logic converting, // sequence active, from the block
  input wire logic [11:0] code_set, // code the core settles on
  input wire logic fire, // request one trigger event
  input wire logic [2:0] sel, // trigger source, as a type code
  output logic [11:0] core_code, // raw code to the block
  output logic pin, // external start pin
  output var logic timer0_trig = 1'b0, // timer zero pulse
  output var logic timer1_trig = 1'b0, // timer one pulse
  output var logic logic_array_trig = 1'b0 // logic array pulse
);
  logic [2:0] pin_cnt_q = 3'h0; // pin high time left

  // code only holds during a conversion; outside it the lines show junk
  assign core_code = converting ? code_set : ~code_set;
  assign pin = (pin_cnt_q != 3'h0); // pin held a few cycles for the synchroniser

  // triggers change just after the edge; timer and array pulses last one cycle
  always @(posedge mclk) begin
    timer0_trig <= fire && sel == adcf_pkg::TYPE_TIMER0;
    timer1_trig <= fire && sel == adcf_pkg::TYPE_TIMER1;
    logic_array_trig <= fire && sel == adcf_pkg::TYPE_LOGIC;
    if (fire && sel == adcf_pkg::TYPE_PIN) begin
      pin_cnt_q <= 3'h4;
    end else if (pin_cnt_q != 3'h0) begin
      pin_cnt_q <= pin_cnt_q - 3'h1;
    end
  end
endmodule
`default_nettype wire

/* bench/adcf_seq_tb.sv */
// adcf_seq_tb: register-level tests of the adc sequencer and result format
// assumes adcf_core_model stands in for the core and trigger sources
`timescale 1ns/10ps
`default_nettype none
module adcf_seq_tb;
  localparam logic [31:0] RES = adcf_pkg::ADDR_RESULT; // result address
  localparam logic [31:0] CTL = adcf_pkg::ADDR_CONTROL; // control address
  logic mclk, rst, fire, temp_channel; // clock, reset, trigger request, temp select
  logic [2:0] sel; // trigger source to fire
  logic [11:0] code_set, core_code; // core code set and seen
  logic pin, t0, t1, la; // trigger lines from the model
  logic sample_hold, converting, result_ready, power_on, diff_mode, temp_sensor_en, adc_ready;
  logic [31:0] rdata, d; // read data port and scratch
  logic [11:0] v; // expected signed code
  adcf_pkg::adcf_mmr_type memory_mapped_register; // register access
  int errors, tests_run, cyc, n, sh; // counters and scratch; sh counts track cycles

  adcf_seq dut (.mclk(mclk), .rst(rst), .memory_mapped_register(memory_mapped_register), .rdata(rdata),
    .ext_conversion_trigger_pin(pin), .timer0_trig(t0), .timer1_trig(t1),
    .logic_array_trig(la), .temp_channel(temp_channel), .core_code(core_code),
    .sample_hold(sample_hold), .converting(converting), .result_ready(result_ready),
    .power_on(power_on), .diff_mode(diff_mode), .temp_sensor_en(temp_sensor_en),
    .adc_ready(adc_ready));
  adcf_core_model core (.mclk(mclk), .converting(converting), .code_set(code_set),
    .fire(fire), .sel(sel), .core_code(core_code), .pin(pin), .timer0_trig(t0),
    .timer1_trig(t1), .logic_array_trig(la));

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // hang guard: the whole run needs well under 20000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write strobe, held over one rising edge
  task automatic wr_reg(input logic [31:0] a, input logic [15:0] w);
    @(negedge mclk);
    memory_mapped_register.addr = a;
    memory_mapped_register.wdata = {16'h0000, w};
    memory_mapped_register.wr = 1'b1;
    @(negedge mclk);
    memory_mapped_register.wr = 1'b0;
  endtask

  // read data lands the cycle after the strobe edge
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] r);
    @(negedge mclk);
    memory_mapped_register.addr = a;
    memory_mapped_register.rd = 1'b1;
    @(negedge mclk);
    memory_mapped_register.rd = 1'b0;
    r = rdata;
  endtask

  task automatic pulse(input logic [2:0] s);
    @(negedge mclk);
    sel = s;
    fire = 1'b1;
    @(negedge mclk);
    fire = 1'b0;
  endtask

  // waits up to 300 cycles for a start, returns cycles spent converting
  task automatic run_conv(output int c);
    int w;
    c = 0;
    w = 0;
    sh = 0;
    while (converting !== 1'b1 && w < 300) begin
      @(negedge mclk);
      w++;
    end
    while (converting === 1'b1 && c < 3000) begin
      if (sample_hold === 1'b1) sh++;
      @(negedge mclk);
      c++;
    end
  endtask

  // length window: tick phase at the start is unknown, write cycle adds one;
  // the track phase is checked too, one cycle of slack for a fresh divider
  task automatic rng(input int c, input int a, input int dv);
    int p;
    p = 1 << dv;
    chk({31'h0, c >= ((2 << a) + 18) * p + 1 && c <= ((2 << a) + 19) * p + 3}, 32'h1);
    chk({31'h0, sh >= ((2 << a) - 1) * p + 1 && sh <= (2 << a) * p + 1}, 32'h1);
  endtask

  // temp bit set for single software conversions, clear otherwise
  function automatic logic [15:0] ctl(input logic [1:0] a, input logic [2:0] dv,
      input logic [2:0] t, input logic [1:0] m, input logic en);
    ctl = {2'b00, t == adcf_pkg::TYPE_SINGLE, dv, a, en, 1'b0, 1'b1, m, t};
  endfunction

  initial begin
    logic [2:0] tt[4];
    tt = '{adcf_pkg::TYPE_PIN, adcf_pkg::TYPE_TIMER1, adcf_pkg::TYPE_TIMER0,
      adcf_pkg::TYPE_LOGIC};
    memory_mapped_register = '0;
    rst = 1'b1;
    fire = 1'b0;
    sel = 3'h0;
    temp_channel = 1'b0;
    code_set = 12'h000;
    errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    rd_reg(CTL, d);
    chk(d, 32'h0000_0600);
    chk({31'h0, power_on}, 32'h0);
    wr_reg(CTL, 16'hc660);
    rd_reg(CTL, d);
    chk(d, 32'h0000_0620);
    rd_reg(32'hffff_0508, d);
    chk(d, 32'h0);
    repeat (60) @(negedge mclk);
    chk({30'h0, power_on, adc_ready}, 32'h3);
    $display("test reset and map done");
    // acquisition codes at divide by two, then every divider at acq code 0
    for (int i = 0; i < 10; i++) begin
      code_set = 12'h5a0 + 12'(i);
      wr_reg(CTL, ctl(i < 4 ? 2'(i) : 2'h0, i < 4 ? 3'h1 : 3'(i - 4), 3'h3, 2'h0, 1'b1));
      run_conv(n);
      rng(n, i < 4 ? i : 0, i < 4 ? 1 : i - 4);
      chk({31'h0, result_ready}, 32'h1);
      rd_reg(RES, d);
      chk(d, {4'h0, code_set, 16'h0000});
      chk({31'h0, result_ready}, 32'h0);
      rd_reg(CTL, d);
      chk({29'h0, d[2:0]}, 32'h0);
    end
    $display("test timing and straight binary done");
    // differential codes at both ends and mid scale
    for (int i = 0; i < 3; i++) begin
      code_set = i == 0 ? 12'h000 : (i == 1 ? 12'hfff : 12'h801);
      wr_reg(CTL, ctl(2'h0, 3'h0, 3'h3, 2'h1, 1'b1));
      chk({31'h0, diff_mode}, 32'h1);
      run_conv(n);
      // offset code minus half scale, then halved: -1024, +1023 and zero
      v = i == 0 ? 12'hc00 : (i == 1 ? 12'h3ff : 12'h000);
      wr_reg(RES, 16'hffff);
      rd_reg(RES, d);
      chk(d, {{4{v[11]}}, v, 16'h0000});
    end
    $display("test differential done");
    wr_reg(CTL, ctl(2'h0, 3'h2, 3'h3, 2'h0, 1'b1));
    run_conv(n);
    rng(n, 0, 2);
    wr_reg(CTL, ctl(2'h0, 3'h6, 3'h3, 2'h0, 1'b1));
    run_conv(n);
    rng(n, 0, 2);
    $display("test reserved divider done");
    // each hardware trigger source (pin, both timers, logic array) refused with start disabled, taken with it set
    for (int i = 0; i < 4; i++) begin
      wr_reg(CTL, ctl(2'h0, 3'h0, tt[i], 2'h0, 1'b0));
      pulse(tt[i]);
      run_conv(n);
      chk(n, 0);
      wr_reg(CTL, ctl(2'h0, 3'h0, tt[i], 2'h0, 1'b1));
      pulse(tt[i]);
      run_conv(n);
      rng(n, 0, 0);
    end
    $display("test triggers done");
    wr_reg(CTL, ctl(2'h0, 3'h0, 3'h4, 2'h0, 1'b1));
    run_conv(n);
    run_conv(n);
    rng(n, 0, 0);
    wr_reg(CTL, ctl(2'h0, 3'h0, 3'h4, 2'h0, 1'b0));
    run_conv(n);
    run_conv(n);
    rng(n, 0, 0);
    wr_reg(CTL, ctl(2'h0, 3'h0, 3'h0, 2'h0, 1'b0));
    run_conv(n);
    run_conv(n);
    chk(n, 0);
    $display("test continuous done");
    temp_channel = 1'b1;
    wr_reg(CTL, 16'h37a3);
    chk({31'h0, temp_sensor_en}, 32'h1);
    run_conv(n);
    rng(n, 3, 5);
    rd_reg(RES, d);
    chk(d, {4'h0, code_set, 16'h0000});
    temp_channel = 1'b0;
    wr_reg(CTL, ctl(2'h0, 3'h0, 3'h3, 2'h0, 1'b1));
    run_conv(n);
    rng(n, 0, 0);
    $display("test temperature done");
    final_report();
  end
endmodule
`default_nettype wire
